// ===== verilog/rctm_pkg.sv
`default_nettype none
package rctm_pkg;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] MODE_OFS   = 12'h004;
   localparam logic [11:0] IRQEN_OFS  = 12'h008;
   localparam logic [11:0] RELOAD_OFS = 12'h00C;
   localparam logic [11:0] COUNT_OFS  = 12'h010;

   // Control register fields
   localparam int CTRL_CAPTURE_SEL_BIT = 0;
   localparam int CTRL_COUNTER_SEL_BIT = 1;
   localparam int CTRL_RUN_BIT         = 2;
   localparam int CTRL_EXT_EVENT_BIT   = 3;
   localparam int CTRL_TX_BAUD_BIT     = 4;
   localparam int CTRL_RX_BAUD_BIT     = 5;
   localparam int CTRL_EDGE_FLAG_BIT   = 6;
   localparam int CTRL_OVF_FLAG_BIT    = 7;

   // Mode register fields
   localparam int MODE_DOWN_EN_BIT     = 0;
   localparam int MODE_CLK_OUT_BIT     = 1;
   localparam int MODE_FREQ_SEL_BIT    = 2;

   // Interrupt enable register fields
   localparam int IRQEN_TIMER_BIT      = 0;
   localparam int IRQEN_GLOBAL_BIT     = 1;

   // Reset values and counter limits
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [15:0] CNT_RST      = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [15:0] CNT_ONE      = 16'h0001;
   localparam logic [3:0]  PRESCALE_DIV = 4'hC;
   localparam logic [3:0]  PRESCALE_ONE = 4'h1;

   // Complete state of the timer block
   typedef struct packed {
      logic        capture_reload_sel;
      logic        counter_mode_sel;
      logic        run_bit;
      logic        ext_event_enable;
      logic        tx_baud_sel;
      logic        rx_baud_sel;
      logic        ext_edge_flag;
      logic        overflow_flag;
      logic        down_count_enable;
      logic        clock_out_enable;
      logic        input_freq_sel;
      logic        timer_irq_enable;
      logic        global_irq_enable;
      logic [15:0] reload;
      logic [15:0] count;
      logic [2:0]  evt_sync;
      logic [2:0]  clk_sync;
      logic        evt_lvl;
      logic        clk_lvl;
      logic [3:0]  prescale;
      logic        half_div;
      logic        clk_out;
      logic        irq;
      logic        tx_tick;
      logic        rx_tick;
      logic [31:0] rdata;
   } rctm_state_type;

endpackage
`default_nettype wire

// ===== verilog/rctm_timer.sv
// Design decisions made here: the APB slave port and the address map.
`default_nettype none
module rctm_timer
(
   input  wire logic        sys_clk_i,          // System clock
   input  wire logic        rstn_i,             // Asynchronous reset, active low
   input  wire logic        psel_i,             // APB select
   input  wire logic        penable_i,          // APB access phase
   input  wire logic        pwrite_i,           // APB direction
   input  wire logic [11:0] paddr_i,            // APB byte address
   input  wire logic [31:0] pwdata_i,           // APB write data
   output logic      [31:0] prdata_o,           // APB read data
   output logic             pready_o,           // APB ready
   output logic             pslverr_o,          // APB error on unmapped address
   input  wire logic        event_pin_i,        // External event pin
   input  wire logic        clock_io_pin_i,     // Clock pin, input side
   output logic             clock_io_pin_o,     // Clock pin, output side
   output logic             clock_io_pin_oe_o,  // Clock pin drive enable
   input  wire logic        other_tx_tick_i,    // Transmit baud tick of the other timer
   input  wire logic        other_rx_tick_i,    // Receive baud tick of the other timer
   output logic             tx_baud_tick_o,     // Selected transmit baud tick
   output logic             rx_baud_tick_o,     // Selected receive baud tick
   output logic             irq_o               // Shared timer interrupt
);

   // Whole block state lives in one struct
   // Registered state and its next value
   rctm_pkg::rctm_state_type state_ff;
   rctm_pkg::rctm_state_type nxt_state;

   // Bus decode terms
   logic        setup_phase;    // First cycle of a transfer
   logic        wr_access;      // Write takes effect
   logic        addr_hit;       // Address maps to a register

   // Mode decode terms
   logic        clk_out_mode;   // Programmable clock output
   logic        baud_mode;      // Either direction uses this timer
   logic        updown_mode;    // Pin steers direction
   logic        count_up;       // Current direction
   logic        evt_fall;       // Filtered falling edge on event pin
   logic        clk_fall;       // Filtered falling edge on clock pin
   logic        evt_filt;       // Next filtered event level
   logic        clk_filt;       // Next filtered clock level
   logic        base_tick;      // Divided or undivided input clock
   logic        tick;           // Counter advance this cycle
   logic        ovf;            // Overflow event this cycle
   logic        edge_set;       // Hardware sets edge flag
   logic        ovf_set;        // Hardware sets overflow flag
   logic        prescale_wrap;  // Divide-by-twelve boundary

   // APB phase decode
   always_comb
   begin
      // Setup cycle latches read data
      setup_phase = psel_i & ~penable_i;
      // Writes land in the access cycle
      wr_access   = psel_i & penable_i & pwrite_i;
      // Only the five word offsets answer
      addr_hit    = (paddr_i == rctm_pkg::CTRL_OFS) | (paddr_i == rctm_pkg::MODE_OFS)
                  | (paddr_i == rctm_pkg::IRQEN_OFS) | (paddr_i == rctm_pkg::RELOAD_OFS)
                  | (paddr_i == rctm_pkg::COUNT_OFS);
   end

   // Pin filters: a change counts once second and third stages agree
   always_comb
   begin
      // Hold last level while stages disagree
      evt_filt = (state_ff.evt_sync[1] == state_ff.evt_sync[2]) ? state_ff.evt_sync[2] : state_ff.evt_lvl;
      // Clock pin filtered the same way
      clk_filt = (state_ff.clk_sync[1] == state_ff.clk_sync[2]) ? state_ff.clk_sync[2] : state_ff.clk_lvl;
      // Falling edges of the filtered levels
      evt_fall = state_ff.evt_lvl & ~evt_filt;
      clk_fall = state_ff.clk_lvl & ~clk_filt;
   end

   // Mode selection and counting source
   always_comb
   begin
      // Clock output needs timer use of the pin
      clk_out_mode  = ~state_ff.counter_mode_sel & state_ff.clock_out_enable;
      // Clock output outranks baud use
      baud_mode     = (state_ff.tx_baud_sel | state_ff.rx_baud_sel) & ~clk_out_mode;
      // Up/down only in plain reload use
      updown_mode   = ~baud_mode & ~clk_out_mode & ~state_ff.capture_reload_sel
                    & state_ff.down_count_enable;
      count_up      = ~updown_mode | state_ff.evt_lvl;
      // Prescaler wraps after twelve clocks
      prescale_wrap = (state_ff.prescale == rctm_pkg::PRESCALE_DIV - rctm_pkg::PRESCALE_ONE);
      base_tick     = state_ff.input_freq_sel | prescale_wrap;
      // Pick what advances the count
      if (baud_mode)
      begin
         // Baud generation counts at the system clock
         tick = state_ff.run_bit;
      end
      else if (state_ff.counter_mode_sel & ~clk_out_mode)
      begin
         // External clock pin counting
         tick = state_ff.run_bit & clk_fall;
      end
      else
      begin
         // Internal clock counting
         tick = state_ff.run_bit & base_tick;
      end
      // Up wraps at all ones, down at reload
      if (count_up)
      begin
         ovf = tick & (state_ff.count == rctm_pkg::CNT_MAX);
      end
      else
      begin
         ovf = tick & (state_ff.count == state_ff.reload);
      end
   end

   // Hardware flag set terms
   always_comb
   begin
      // Hardware only sets the flags, except the up/down toggle of the edge flag
      // Overflow flag only outside baud and clock output use
      ovf_set  = ovf & ~baud_mode & ~clk_out_mode;
      // Edge flag from event pin; in up/down use it is a result bit
      edge_set = evt_fall & state_ff.ext_event_enable & ~updown_mode;
   end

   // Next state
   always_comb
   begin
      nxt_state = state_ff;
      // Everything holds unless changed below

      // Three-stage synchronisers and filtered levels
      nxt_state.evt_sync = {state_ff.evt_sync[1:0], event_pin_i};
      nxt_state.clk_sync = {state_ff.clk_sync[1:0], clock_io_pin_i};
      // Filtered levels feed the edge detectors
      nxt_state.evt_lvl  = evt_filt;
      nxt_state.clk_lvl  = clk_filt;

      // Divide-by-twelve prescaler
      if (prescale_wrap)
      begin
         // Restart the divide
         nxt_state.prescale = 4'h0;
      end
      else
      begin
         // Step towards the wrap
         nxt_state.prescale = state_ff.prescale + rctm_pkg::PRESCALE_ONE;
      end

      // Counter advance
      if (tick)
      begin
         if (count_up)
         begin
            if (ovf)
            begin
               // Capture use has no reload
               if (state_ff.capture_reload_sel & ~baud_mode & ~clk_out_mode)
               begin
                  // Capture use wraps freely
                  nxt_state.count = rctm_pkg::CNT_RST;
               end
               else
               begin
                  // Reload, baud and clock output reload on overflow
                  nxt_state.count = state_ff.reload;
               end
            end
            else
            begin
               // Step up by one
               nxt_state.count = state_ff.count + rctm_pkg::CNT_ONE;
            end
         end
         else
         begin
            // Down count wraps at the reload match
            if (ovf)
            begin
               nxt_state.count = rctm_pkg::CNT_MAX;
            end
            else
            begin
               // Step down by one
               nxt_state.count = state_ff.count - rctm_pkg::CNT_ONE;
            end
         end
      end

      // Event edge actions
      // Edge acts in capture and plain reload only
      if (evt_fall & state_ff.ext_event_enable & ~updown_mode & ~baud_mode & ~clk_out_mode)
      begin
         // Capture copies even while stopped
         if (state_ff.capture_reload_sel)
         begin
            // Copy count into reload/capture register
            nxt_state.reload = state_ff.count;
         end
         else if (state_ff.run_bit)
         begin
            // Edge-triggered reload
            nxt_state.count = state_ff.reload;
         end
      end

      // Clock output: toggle every second overflow for a divide by four
      if (clk_out_mode & ovf)
      begin
         // Half divider picks every second wrap
         nxt_state.half_div = ~state_ff.half_div;
         if (state_ff.half_div)
         begin
            nxt_state.clk_out = ~state_ff.clk_out;
         end
      end
      if (~clk_out_mode)
      begin
         // Park divider and pin low when unused
         nxt_state.half_div = 1'b0;
         nxt_state.clk_out  = 1'b0;
      end

      // Baud ticks per direction
      // Unselected direction passes the other timer
      // Ticks leave one clock after the wrap
      nxt_state.tx_tick = state_ff.tx_baud_sel ? (baud_mode & ovf) : other_tx_tick_i;
      nxt_state.rx_tick = state_ff.rx_baud_sel ? (baud_mode & ovf) : other_rx_tick_i;

      // Register writes
      if (wr_access)
      begin
         unique case (paddr_i)
            rctm_pkg::CTRL_OFS:
            begin
               // Use and mode selection bits
               nxt_state.capture_reload_sel = pwdata_i[rctm_pkg::CTRL_CAPTURE_SEL_BIT];
               nxt_state.counter_mode_sel   = pwdata_i[rctm_pkg::CTRL_COUNTER_SEL_BIT];
               nxt_state.run_bit            = pwdata_i[rctm_pkg::CTRL_RUN_BIT];
               nxt_state.ext_event_enable   = pwdata_i[rctm_pkg::CTRL_EXT_EVENT_BIT];
               nxt_state.tx_baud_sel        = pwdata_i[rctm_pkg::CTRL_TX_BAUD_BIT];
               nxt_state.rx_baud_sel        = pwdata_i[rctm_pkg::CTRL_RX_BAUD_BIT];
               // Software may set or clear either flag
               nxt_state.ext_edge_flag      = pwdata_i[rctm_pkg::CTRL_EDGE_FLAG_BIT];
               nxt_state.overflow_flag      = pwdata_i[rctm_pkg::CTRL_OVF_FLAG_BIT];
            end
            rctm_pkg::MODE_OFS:
            begin
               // Direction, pin drive and divider
               nxt_state.down_count_enable = pwdata_i[rctm_pkg::MODE_DOWN_EN_BIT];
               nxt_state.clock_out_enable  = pwdata_i[rctm_pkg::MODE_CLK_OUT_BIT];
               nxt_state.input_freq_sel    = pwdata_i[rctm_pkg::MODE_FREQ_SEL_BIT];
            end
            rctm_pkg::IRQEN_OFS:
            begin
               // Timer and global enables
               nxt_state.timer_irq_enable  = pwdata_i[rctm_pkg::IRQEN_TIMER_BIT];
               nxt_state.global_irq_enable = pwdata_i[rctm_pkg::IRQEN_GLOBAL_BIT];
            end
            rctm_pkg::RELOAD_OFS:
            begin
               // Rewriting during baud use disturbs the rate
               nxt_state.reload = pwdata_i[15:0];
            end
            rctm_pkg::COUNT_OFS:
            begin
               nxt_state.count = pwdata_i[15:0];
            end
            default:
            begin
               // Unmapped write is dropped
               nxt_state.reload = nxt_state.reload;
            end
         endcase
      end

      // Hardware sets win over a software clear in the same cycle
      // Overflow outside baud and clock out
      if (ovf_set)
      begin
         nxt_state.overflow_flag = 1'b1;
      end
      // Event edge recorded
      if (edge_set)
      begin
         nxt_state.ext_edge_flag = 1'b1;
      end
      if (updown_mode & ovf)
      begin
         // Seventeenth result bit toggles on each wrap
         nxt_state.ext_edge_flag = ~state_ff.ext_edge_flag;
      end

      // Shared interrupt request
      // Level follows the flags a clock late
      nxt_state.irq = state_ff.global_irq_enable & state_ff.timer_irq_enable
                    & (state_ff.overflow_flag | (state_ff.ext_edge_flag & ~updown_mode));

      // Read data captured in the setup cycle
      if (setup_phase)
      begin
         unique case (paddr_i)
            rctm_pkg::CTRL_OFS:
            begin
               // Flags sit in the top two bits
               nxt_state.rdata = {24'h000000, state_ff.overflow_flag, state_ff.ext_edge_flag,
                                  state_ff.rx_baud_sel, state_ff.tx_baud_sel, state_ff.ext_event_enable,
                                  state_ff.run_bit, state_ff.counter_mode_sel, state_ff.capture_reload_sel};
            end
            rctm_pkg::MODE_OFS:
            begin
               // Mode bits
               nxt_state.rdata = {29'h00000000, state_ff.input_freq_sel, state_ff.clock_out_enable,
                                  state_ff.down_count_enable};
            end
            rctm_pkg::IRQEN_OFS:
            begin
               // Both enable bits
               nxt_state.rdata = {30'h00000000, state_ff.global_irq_enable, state_ff.timer_irq_enable};
            end
            rctm_pkg::RELOAD_OFS:
            begin
               // Reload or captured value
               nxt_state.rdata = {16'h0000, state_ff.reload};
            end
            rctm_pkg::COUNT_OFS:
            begin
               // Count as it stood at setup
               nxt_state.rdata = {16'h0000, state_ff.count};
            end
            default:
            begin
               // Unmapped reads return zero
               nxt_state.rdata = 32'h00000000;
            end
         endcase
      end
   end

   // State register
   // Single register for the whole state
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         // All state clears, pins idle low
         state_ff <= '0;
      end
      else
      begin
         // Take the next state
         state_ff <= nxt_state;
      end
   end

   // Outputs
   always_comb
   begin
      // Bus answers in the access cycle
      prdata_o          = state_ff.rdata;
      pready_o          = psel_i & penable_i;                            // Zero wait states
      pslverr_o         = psel_i & penable_i & ~addr_hit;
      clock_io_pin_o    = state_ff.clk_out;
      clock_io_pin_oe_o = state_ff.clock_out_enable & ~state_ff.counter_mode_sel;
      // Ticks and interrupt from flip-flops
      tx_baud_tick_o    = state_ff.tx_tick;
      rx_baud_tick_o    = state_ff.rx_tick;
      irq_o             = state_ff.irq;
   end

endmodule
`default_nettype wire

// ===== bench/rctm_timer_monitor.sv
`default_nettype none
module rctm_chk
(
   input wire logic        sys_clk_i,
   input wire logic        rstn_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        clock_io_pin_oe_o,
   input wire logic        other_tx_tick_i,
   input wire logic        other_rx_tick_i,
   input wire logic        tx_baud_tick_o,
   input wire logic        rx_baud_tick_o,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       acc_c;  // Access phase
   logic       map_c;  // Address hits a register
   logic       wr_c;   // Write takes effect
   logic       ctw_c;  // Write to control
   logic       en_c;   // Both interrupt enables
   logic [5:0] cfg_ff; // Shadow: rx, tx, counter, clock out, global, timer
   assign acc_c = psel_i && penable_i;
   assign map_c = paddr_i[1:0] == 2'h0 && paddr_i <= rctm_pkg::COUNT_OFS;
   assign wr_c  = acc_c && pwrite_i && map_c;
   assign ctw_c = wr_c && paddr_i == rctm_pkg::CTRL_OFS;
   assign en_c  = cfg_ff[1] && cfg_ff[0];
   // Shadow of the mode bits that software wrote
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cfg_ff <= 6'h00;
      else if (ctw_c)
         cfg_ff[5:3] <= {pwdata_i[5], pwdata_i[4], pwdata_i[1]};
      else if (wr_c && paddr_i == rctm_pkg::MODE_OFS)
         cfg_ff[2] <= pwdata_i[1];
      else if (wr_c && paddr_i == rctm_pkg::IRQEN_OFS)
         cfg_ff[1:0] <= pwdata_i[1:0];
   end
   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   a_ready_access: assert property (pready_o == acc_c) else $error("ready outside access");
   a_err_unmapped: assert property (acc_c && !map_c |-> pslverr_o) else $error("no error on hole");
   a_err_mapped: assert property (acc_c && map_c |-> !pslverr_o) else $error("error on register");
   a_rx_pass: assert property (!cfg_ff[5] |=> rx_baud_tick_o == $past(other_rx_tick_i))
      else $error("rx tick not passed");
   a_tx_pass: assert property (!cfg_ff[4] |=> tx_baud_tick_o == $past(other_tx_tick_i))
      else $error("tx tick not passed");
   a_oe_mode: assert property (clock_io_pin_oe_o == (cfg_ff[2] && !cfg_ff[3]))
      else $error("pin drive wrong");
   a_irq_gate: assert property (irq_o |-> $past(en_c)) else $error("irq without enables");
   a_irq_drop: assert property ($fell(en_c) |=> !irq_o) else $error("irq after disable");
   a_irq_hold: assert property (irq_o && en_c && !ctw_c && !$past(ctw_c) |=> irq_o)
      else $error("flag cleared by hardware");
   c_irq: cover property (irq_o);
   c_hole: cover property (acc_c && !map_c);
   c_clkout: cover property ($rose(clock_io_pin_oe_o));
endmodule
bind rctm_timer rctm_chk chk_u (.sys_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
   .pready_o, .pslverr_o, .clock_io_pin_oe_o, .other_tx_tick_i, .other_rx_tick_i, .tx_baud_tick_o,
   .rx_baud_tick_o, .irq_o);
`default_nettype wire

// ===== bench/rctm_far_model.sv
`default_nettype none
module rctm_far
(
   input  wire logic sys_clk_i, // System clock
   input  wire logic rstn_i,    // Reset, active low
   output logic      ev_o,      // Event pin
   output logic      clk_o,     // Clock pin when not driven by the timer
   output logic      tx_tick_o, // Other timer transmit tick
   output logic      rx_tick_o  // Other timer receive tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] div_ff = 4'h0; // Tick divider of the other timer
   initial
   begin
      ev_o = 1'b1;
      clk_o = 1'b1;
   end
   // Other timer ticks, one cycle wide, period 7
   always @(posedge sys_clk_i)
      div_ff <= (!rstn_i || div_ff == 4'h6) ? 4'h0 : div_ff + 4'h1;
   assign tx_tick_o = rstn_i && div_ff == 4'h2;
   assign rx_tick_o = rstn_i && div_ff == 4'h5;
   // Set the event pin level, held past the filter
   task automatic set_event(input logic lvl);
      ev_o <= lvl;
      repeat (6) @(posedge sys_clk_i);
   endtask
   // One falling edge on the event pin
   task automatic fall_event();
      set_event(1'b0);
      set_event(1'b1);
   endtask
   // Falling edges on the clock pin
   task automatic pulse_clk(input int n);
      repeat (n)
      begin
         clk_o <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
         clk_o <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
      end
   endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] CT = rctm_pkg::CTRL_OFS;   // Control
   localparam logic [11:0] MD = rctm_pkg::MODE_OFS;   // Mode
   localparam logic [11:0] IE = rctm_pkg::IRQEN_OFS;  // Interrupt enables
   localparam logic [11:0] RL = rctm_pkg::RELOAD_OFS; // Reload
   localparam logic [11:0] CN = rctm_pkg::COUNT_OFS;  // Count
   logic        sys_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, q, q2, seed = 32'h0000F181; // Seed 61825
   logic        pready_o, pslverr_o, event_pin_i, fclk, clock_io_pin_o, clock_io_pin_oe_o, err;
   logic        other_tx_tick_i, other_rx_tick_i, tx_baud_tick_o, rx_baud_tick_o, irq_o;
   wire logic   clock_io_pin_i = clock_io_pin_oe_o ? clock_io_pin_o : fclk; // Pin level
   int          bad_count = 0, num_checks = 0, n, h;
   rctm_timer dut_u (.sys_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .event_pin_i, .clock_io_pin_i, .clock_io_pin_o, .clock_io_pin_oe_o,
      .other_tx_tick_i, .other_rx_tick_i, .tx_baud_tick_o, .rx_baud_tick_o, .irq_o);
   rctm_far far_u (.sys_clk_i, .rstn_i, .ev_o(event_pin_i), .clk_o(fclk), .tx_tick_o(other_tx_tick_i),
      .rx_tick_o(other_rx_tick_i));
   always #20 sys_clk_i = ~sys_clk_i;
   // Random source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // One APB transfer, result in q and err
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   // Verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      bad_count++;
      final_report();
   end
   initial
   begin
      repeat (6) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      @(posedge sys_clk_i);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, 12'(4 * i), 32'h0);
         `CHK(q, 32'h0)
      end
      apb(1'b0, 12'h040, 32'h0);
      `CHK({err, q}, 33'h100000000)
      // Stopped timer keeps random values
      for (int i = 0; i < 4; i++)
      begin
         q2 = xs() & 32'h0000FFFF;
         apb(1'b1, RL, q2);
         apb(1'b1, CN, q2 ^ 32'h0000FFFF);
         repeat (5) @(posedge sys_clk_i);
         apb(1'b0, CN, 32'h0);
         `CHK(q, q2 ^ 32'h0000FFFF)
         apb(1'b0, RL, 32'h0);
         `CHK(q, q2)
      end
      // Up count with reload, then flags and interrupt
      apb(1'b1, MD, 32'h4);
      apb(1'b1, RL, 32'hFFF0);
      apb(1'b1, CN, 32'hFFF8);
      apb(1'b1, IE, 32'h1);
      apb(1'b1, CT, 32'h4);
      repeat (12) @(posedge sys_clk_i);
      apb(1'b0, CT, 32'h0);
      `CHK(q, 32'h84)
      `CHK(irq_o, 1'b0)
      apb(1'b0, CN, 32'h0);
      `CHK(q[15:0] >= 16'hFFF0, 1'b1)
      apb(1'b1, IE, 32'h3);
      apb(1'b1, CT, 32'h80);
      repeat (20) @(posedge sys_clk_i);
      `CHK(irq_o, 1'b1)
      apb(1'b0, CT, 32'h0);
      `CHK(q, 32'h80)
      apb(1'b1, CT, 32'h0);
      repeat (3) @(posedge sys_clk_i);
      `CHK(irq_o, 1'b0)
      apb(1'b1, CT, 32'h40);
      repeat (3) @(posedge sys_clk_i);
      `CHK(irq_o, 1'b1)
      // Input clock divided by 12, then stopped
      apb(1'b1, MD, 32'h0);
      apb(1'b1, CN, 32'h0);
      apb(1'b1, CT, 32'h4);
      repeat (240) @(posedge sys_clk_i);
      apb(1'b1, CT, 32'h0);
      apb(1'b0, CN, 32'h0);
      q2 = q;
      `CHK(q[15:0] >= 16'h0014 && q[15:0] <= 16'h0016, 1'b1)
      repeat (30) @(posedge sys_clk_i);
      apb(1'b0, CN, 32'h0);
      `CHK(q, q2)
      // Capture on event edge, running then stopped
      apb(1'b1, MD, 32'h4);
      apb(1'b1, CN, 32'h1000);
      apb(1'b1, CT, 32'hD);
      far_u.fall_event();
      apb(1'b0, RL, 32'h0);
      q2 = q;
      apb(1'b0, CN, 32'h0);
      `CHK(q2[15:0] > 16'h1000 && q2[15:0] < q[15:0], 1'b1)
      apb(1'b0, CT, 32'h0);
      `CHK(q, 32'h4D)
      apb(1'b1, CT, 32'h9);
      far_u.fall_event();
      apb(1'b0, RL, 32'h0);
      q2 = q;
      apb(1'b0, CN, 32'h0);
      `CHK(q, q2)
      // Reload on event edge
      apb(1'b1, RL, 32'h2000);
      apb(1'b1, CN, 32'h3000);
      apb(1'b1, CT, 32'hC);
      far_u.fall_event();
      apb(1'b0, CN, 32'h0);
      `CHK(q[15:0] >= 16'h2000 && q[15:0] < 16'h2020, 1'b1)
      apb(1'b0, CT, 32'h0);
      `CHK(q, 32'h4C)
      // Down count with pin low, then up with pin high
      apb(1'b1, CT, 32'h0);
      far_u.set_event(1'b0);
      apb(1'b1, MD, 32'h5);
      apb(1'b1, RL, 32'h0100);
      apb(1'b1, CN, 32'h0108);
      apb(1'b1, CT, 32'h4);
      repeat (10) @(posedge sys_clk_i);
      apb(1'b0, CT, 32'h0);
      `CHK(q, 32'hC4)
      apb(1'b0, CN, 32'h0);
      `CHK(q[15:0] >= 16'hFF00, 1'b1)
      apb(1'b1, CT, 32'h0);
      far_u.set_event(1'b1);
      apb(1'b1, CN, 32'hFFF8);
      apb(1'b1, CT, 32'hC);
      repeat (10) @(posedge sys_clk_i);
      apb(1'b0, CN, 32'h0);
      `CHK(q[15:0] >= 16'h0100 && q[15:0] < 16'h0120, 1'b1)
      apb(1'b0, CT, 32'h0);
      `CHK(q[7:6], 2'b11)
      // Baud source per direction, configured while stopped
      apb(1'b1, MD, 32'h0);
      apb(1'b1, RL, 32'hFFF0);
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, CT, 32'h0);
         apb(1'b1, CN, 32'hFFF0);
         apb(1'b1, CT, 32'h0C | (32'h10 << k));
         n = 0;
         repeat (160)
         begin
            @(negedge sys_clk_i);
            n += k ? rx_baud_tick_o : tx_baud_tick_o;
         end
         `CHK(n >= 9 && n <= 11, 1'b1)
         apb(1'b0, CT, 32'h0);
         `CHK({irq_o, q}, 33'(32'h0C | (32'h10 << k)))
         far_u.fall_event();
         apb(1'b0, CT, 32'h0);
         `CHK(q, 32'h4C | (32'h10 << k))
      end
      // Clock output at reload FFFC gives period 16
      apb(1'b1, CT, 32'h0);
      apb(1'b1, MD, 32'h6);
      apb(1'b1, RL, 32'hFFFC);
      apb(1'b1, CN, 32'hFFFC);
      apb(1'b1, CT, 32'h4);
      `CHK(clock_io_pin_oe_o, 1'b1)
      n = 0;
      h = 0;
      while (clock_io_pin_o !== 1'b1) @(negedge sys_clk_i);
      while (clock_io_pin_o === 1'b1)
      begin
         @(negedge sys_clk_i);
         h++;
      end
      while (clock_io_pin_o !== 1'b1)
      begin
         @(negedge sys_clk_i);
         n++;
      end
      `CHK(n == 8 && h == 8, 1'b1)
      `CHK(irq_o, 1'b0)
      // Counter mode counts clock pin edges
      apb(1'b1, CT, 32'h0);
      apb(1'b1, MD, 32'h0);
      apb(1'b1, CN, 32'h0);
      apb(1'b1, CT, 32'h6);
      far_u.pulse_clk(5);
      apb(1'b0, CN, 32'h0);
      `CHK(q, 32'h5)
      final_report();
   end
endmodule
`default_nettype wire
